// file: include/wpt_defs.svh
// constants for the wake pull, bus fast mode and cyclic timer registers
// assumes a 50 MHz system clock and a 16-bit spi frame
`ifndef WPT_DEFS_SVH
`define WPT_DEFS_SVH
`define WPT_ADDR_PULL     7'h08
`define WPT_ADDR_BUS      7'h0B
`define WPT_ADDR_TMR      7'h0C
`define WPT_RST_VAL       8'h00
`define WPT_MASK_PULL     8'hC3
`define WPT_MASK_BUS      8'h10
`define WPT_MASK_TMR      8'h7F
`define WPT_KEEP_PULL     8'hC3
`define WPT_KEEP_BUS      8'h10
`define WPT_F_GPIO_PULL   7:6
`define WPT_F_WK_PULL     1:0
`define WPT_F_FAST        4
`define WPT_F_ON          6:4
`define WPT_F_PER         3:0
`define WPT_FRAME_BITS    5'h10
`define WPT_HDR_BITS      5'h08
`define WPT_F_WRITE       15
`define WPT_F_ADDR        14:8
`define WPT_F_DATA        7:0
`define WPT_ON_LOW        3'h0
`define WPT_ON_HIGH       3'h6
`define WPT_ON_LAST       3'h5
`define WPT_CLK_NS        20
`define WPT_TICK_NS       100000
`define WPT_TICK_CYC      (`WPT_TICK_NS / `WPT_CLK_NS)
`define WPT_TW            24
`endif

// file: include/wpt_pkg.sv
// types shared by the wake pull, bus fast mode and cyclic timer registers
// assumes wpt_defs.svh for numeric constants
package wpt_pkg;
	typedef enum logic [1:0] {
		WPT_PULL_NONE = 2'h0,
		WPT_PULL_DOWN = 2'h1,
		WPT_PULL_UP   = 2'h2,
		WPT_PULL_AUTO = 2'h3
	} wpt_pull_t;
	typedef struct packed {
		logic pull_up_en;
		logic pull_down_en;
		logic auto_switch_en;
	} wpt_pull_drive_t;
	typedef enum logic [1:0] {
		WPT_TS_STOP = 2'h0,
		WPT_TS_ON   = 2'h1,
		WPT_TS_OFF  = 2'h3
	} wpt_tmr_state_t;
	typedef struct packed {
		logic spi_chip_select_n;
		logic spi_sclk;
		logic spi_mosi;
	} wpt_spi_pins_t;
endpackage

// file: hw/wpt_regs.sv
// wake pull, can fast mode and cyclic timer registers behind an spi slave
// assumes spi pins asynchronous to sys_clk; reset and mode inputs are on sys_clk
`timescale 1ns/1ns
`include "wpt_defs.svh"
module wpt_regs #(
	parameter int TICK_CYC = `WPT_TICK_CYC
) (
	input  wire logic                    sys_clk,
	input  wire logic                    rst_b,
	input  wire wpt_pkg::wpt_spi_pins_t  spi_pins,
	output logic                         spi_miso,
	output logic                         spi_miso_oe_n,
	input  wire logic                    soft_reset_req,
	input  wire logic                    restart_req,
	input  wire logic                    gpio_is_wake_in,
	input  wire logic                    timer_assigned,
	input  wire logic                    cyclic_sense_sel,
	input  wire logic                    hs_clear_in_restart,
	input  wire logic                    timer_wake_source_en,
	output wpt_pkg::wpt_pull_drive_t     gpio_wake_pull_sel,
	output wpt_pkg::wpt_pull_drive_t     wake_pin_pull_sel,
	output logic                         can_fast_mode,
	output logic                         high_side_switch_out,
	output logic                         cyclic_sense_sample,
	output logic                         timer_wake_event
);
	import wpt_pkg::*;

	if (TICK_CYC < 1) begin
		$error("TICK_CYC must be at least 1");
	end
	localparam int PW = $clog2(TICK_CYC + 1);

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [2:0] csn_s_r;
	logic [2:0] sclk_s_r;
	logic [1:0] mosi_s_r;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			csn_s_r  <= 3'h7;
			sclk_s_r <= 3'h0;
			mosi_s_r <= 2'h0;
		end else begin
			csn_s_r  <= {csn_s_r[1:0], spi_pins.spi_chip_select_n};
			sclk_s_r <= {sclk_s_r[1:0], spi_pins.spi_sclk};
			mosi_s_r <= {mosi_s_r[0], spi_pins.spi_mosi};
		end
	end

	logic csn_fall;
	logic csn_rise;
	logic sclk_rise;
	logic sclk_fall;
	logic sel;
	assign csn_fall  = csn_s_r[2] & ~csn_s_r[1];
	assign csn_rise  = ~csn_s_r[2] & csn_s_r[1];
	assign sel       = ~csn_s_r[1];
	assign sclk_rise = sel & ~sclk_s_r[2] & sclk_s_r[1];
	assign sclk_fall = sel & sclk_s_r[2] & ~sclk_s_r[1];

	// ----------------------------------------
	// spi frame
	// ----------------------------------------
	logic [15:0] in_sh_r;
	logic [4:0]  bit_cnt_r;
	logic [7:0]  out_sh_r;
	logic        commit_r;
	logic [6:0]  wr_addr_r;
	logic [7:0]  wr_data_r;
	logic [7:0]  pull_r;
	logic [7:0]  bus_r;
	logic [7:0]  tmr_r;

	function automatic logic [7:0] read_reg(input logic [6:0] a, input logic [7:0] p,
	                                        input logic [7:0] b, input logic [7:0] t);
		logic [7:0] v;
		v = `WPT_RST_VAL;
		unique case (a)
			`WPT_ADDR_PULL: v = p & `WPT_MASK_PULL;
			`WPT_ADDR_BUS:  v = b & `WPT_MASK_BUS;
			`WPT_ADDR_TMR:  v = t & `WPT_MASK_TMR;
			default:        v = `WPT_RST_VAL;
		endcase
		return v;
	endfunction

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			in_sh_r   <= 16'h0000;
			bit_cnt_r <= 5'h00;
		end else if (csn_fall) begin
			in_sh_r   <= 16'h0000;
			bit_cnt_r <= 5'h00;
		end else if (sclk_rise) begin
			in_sh_r <= {in_sh_r[14:0], mosi_s_r[1]};
			if (bit_cnt_r != 5'h1F) begin
				bit_cnt_r <= bit_cnt_r + 5'h01;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			out_sh_r      <= 8'h00;
			spi_miso      <= 1'b0;
			spi_miso_oe_n <= 1'b1;
		end else begin
			spi_miso_oe_n <= ~sel;
			if (csn_fall) begin
				out_sh_r <= 8'h00;
				spi_miso <= 1'b0;
			end else if (sclk_rise && bit_cnt_r == `WPT_HDR_BITS - 5'h01) begin
				out_sh_r <= read_reg({in_sh_r[5:0], mosi_s_r[1]}, pull_r, bus_r, tmr_r);
			end else if (sclk_fall && bit_cnt_r >= `WPT_HDR_BITS) begin
				spi_miso <= out_sh_r[7];
				out_sh_r <= {out_sh_r[6:0], 1'b0};
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			commit_r  <= 1'b0;
			wr_addr_r <= 7'h00;
			wr_data_r <= 8'h00;
		end else begin
			commit_r <= csn_rise && bit_cnt_r == `WPT_FRAME_BITS && in_sh_r[`WPT_F_WRITE];
			if (csn_rise) begin
				wr_addr_r <= in_sh_r[`WPT_F_ADDR];
				wr_data_r <= in_sh_r[`WPT_F_DATA];
			end
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic tmr_clear;
	assign tmr_clear = restart_req | (cyclic_sense_sel & hs_clear_in_restart);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pull_r <= `WPT_RST_VAL;
		end else if (soft_reset_req) begin
			pull_r <= `WPT_RST_VAL;
		end else if (restart_req) begin
			pull_r <= pull_r & `WPT_KEEP_PULL;
		end else if (commit_r && wr_addr_r == `WPT_ADDR_PULL) begin
			pull_r <= wr_data_r & `WPT_MASK_PULL;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			bus_r <= `WPT_RST_VAL;
		end else if (soft_reset_req) begin
			bus_r <= `WPT_RST_VAL;
		end else if (restart_req) begin
			bus_r <= bus_r & `WPT_KEEP_BUS;
		end else if (commit_r && wr_addr_r == `WPT_ADDR_BUS) begin
			bus_r <= wr_data_r & `WPT_MASK_BUS;
		end
	end
	assign can_fast_mode = bus_r[`WPT_F_FAST];

	logic tmr_load;
	assign tmr_load = commit_r && wr_addr_r == `WPT_ADDR_TMR;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tmr_r <= `WPT_RST_VAL;
		end else if (soft_reset_req || tmr_clear) begin
			tmr_r <= `WPT_RST_VAL;
		end else if (tmr_load) begin
			tmr_r <= wr_data_r & `WPT_MASK_TMR;
		end
	end

	// ----------------------------------------
	// pull decode
	// ----------------------------------------
	function automatic wpt_pull_drive_t pull_dec(input logic [1:0] c);
		wpt_pull_drive_t d;
		d = '0;
		unique case (wpt_pull_t'(c))
			WPT_PULL_NONE: d = '0;
			WPT_PULL_DOWN: d.pull_down_en = 1'b1;
			WPT_PULL_UP:   d.pull_up_en = 1'b1;
			WPT_PULL_AUTO: d.auto_switch_en = 1'b1;
		endcase
		return d;
	endfunction

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			gpio_wake_pull_sel <= '0;
			wake_pin_pull_sel  <= '0;
		end else begin
			gpio_wake_pull_sel <= gpio_is_wake_in ? pull_dec(pull_r[`WPT_F_GPIO_PULL]) : '0;
			wake_pin_pull_sel  <= pull_dec(pull_r[`WPT_F_WK_PULL]);
		end
	end

	// ----------------------------------------
	// cyclic timer
	// ----------------------------------------
	function automatic logic [`WPT_TW-1:0] on_ticks(input logic [2:0] c);
		logic [`WPT_TW-1:0] t;
		t = `WPT_TW'(1);
		unique case (c)
			3'h1:    t = `WPT_TW'(1);
			3'h2:    t = `WPT_TW'(3);
			3'h3:    t = `WPT_TW'(10);
			3'h4:    t = `WPT_TW'(100);
			3'h5:    t = `WPT_TW'(200);
			default: t = `WPT_TW'(1);
		endcase
		return t;
	endfunction

	function automatic logic [`WPT_TW-1:0] per_ticks(input logic [3:0] c);
		logic [`WPT_TW-1:0] t;
		t = `WPT_TW'(100);
		unique case (c)
			4'h0: t = `WPT_TW'(100);
			4'h1: t = `WPT_TW'(200);
			4'h2: t = `WPT_TW'(500);
			4'h3: t = `WPT_TW'(1000);
			4'h4: t = `WPT_TW'(2000);
			4'h5: t = `WPT_TW'(5000);
			4'h6: t = `WPT_TW'(10000);
			4'h7: t = `WPT_TW'(20000);
			4'h8: t = `WPT_TW'(50000);
			4'h9: t = `WPT_TW'(100000);
			4'hA: t = `WPT_TW'(200000);
			4'hB: t = `WPT_TW'(500000);
			4'hC: t = `WPT_TW'(1000000);
			4'hD: t = `WPT_TW'(2000000);
			4'hE: t = `WPT_TW'(5000000);
			4'hF: t = `WPT_TW'(10000000);
		endcase
		return t;
	endfunction

	logic [PW-1:0]       pre_r;
	logic [`WPT_TW-1:0]  per_cnt_r;
	wpt_tmr_state_t      ts_r;
	logic                tick;
	logic                run;
	logic [2:0]          on_code;
	assign on_code = tmr_r[`WPT_F_ON];
	assign run     = timer_assigned && on_code != `WPT_ON_LOW && on_code <= `WPT_ON_LAST;
	assign tick    = pre_r == PW'(TICK_CYC - 1);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pre_r <= '0;
		end else if (tmr_load || tick || !run || ts_r == WPT_TS_STOP) begin
			pre_r <= '0;
		end else begin
			pre_r <= pre_r + PW'(1);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			ts_r                 <= WPT_TS_STOP;
			per_cnt_r            <= '0;
			high_side_switch_out <= 1'b0;
			cyclic_sense_sample  <= 1'b0;
			timer_wake_event     <= 1'b0;
		end else begin
			cyclic_sense_sample <= 1'b0;
			timer_wake_event    <= 1'b0;
			if (!run) begin
				ts_r                 <= WPT_TS_STOP;
				per_cnt_r            <= '0;
				high_side_switch_out <= on_code == `WPT_ON_HIGH;
			end else begin
				unique case (ts_r)
					WPT_TS_STOP: begin
						ts_r                 <= WPT_TS_ON;
						per_cnt_r            <= '0;
						high_side_switch_out <= 1'b1;
					end
					WPT_TS_ON: begin
						if (tick) begin
							per_cnt_r <= per_cnt_r + `WPT_TW'(1);
							if (per_cnt_r + `WPT_TW'(1) >= on_ticks(on_code)) begin
								ts_r                 <= WPT_TS_OFF;
								high_side_switch_out <= 1'b0;
								cyclic_sense_sample  <= 1'b1;
							end
						end
					end
					WPT_TS_OFF: begin
						if (tick) begin
							per_cnt_r <= per_cnt_r + `WPT_TW'(1);
							if (per_cnt_r + `WPT_TW'(1) >= per_ticks(tmr_r[`WPT_F_PER])) begin
								ts_r                 <= WPT_TS_ON;
								per_cnt_r            <= '0;
								high_side_switch_out <= 1'b1;
								timer_wake_event     <= timer_wake_source_en;
							end
						end
					end
					default: begin
						ts_r <= WPT_TS_STOP;
					end
				endcase
				if (tmr_load) begin
					ts_r <= WPT_TS_STOP;
				end
			end
		end
	end
endmodule

// file: testbench/wpt_regs_sva.sv
// assertions on the wake pull, bus and timer register ports
// assumes a bind into wpt_regs and one clock domain
`timescale 1ns/1ns
module wpt_regs_sva #(
	parameter int TICK_CYC = 5000
) (
	input wire logic                     sys_clk,
	input wire logic                     rst_b,
	input wire logic                     soft_reset_req,
	input wire logic                     restart_req,
	input wire logic                     gpio_is_wake_in,
	input wire logic                     timer_assigned,
	input wire logic                     cyclic_sense_sel,
	input wire logic                     hs_clear_in_restart,
	input wire logic                     timer_wake_source_en,
	input wire wpt_pkg::wpt_pull_drive_t gpio_wake_pull_sel,
	input wire wpt_pkg::wpt_pull_drive_t wake_pin_pull_sel,
	input wire logic                     can_fast_mode,
	input wire logic                     high_side_switch_out,
	input wire logic                     cyclic_sense_sample,
	input wire logic                     timer_wake_event
);
	import wpt_pkg::*;
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	property p_gate; !gpio_is_wake_in [*2] |-> gpio_wake_pull_sel == 3'h0; endproperty
	property p_soft; soft_reset_req |=> !can_fast_mode ##1 wake_pin_pull_sel == 3'h0; endproperty
	property p_keep; restart_req |=> $stable(wake_pin_pull_sel) && $stable(can_fast_mode); endproperty
	property p_rst_hs; restart_req |-> ##[1:4] !high_side_switch_out; endproperty
	property p_clr; hs_clear_in_restart && cyclic_sense_sel |-> ##[1:4] !high_side_switch_out; endproperty
	property p_wake; timer_wake_event |-> $past(timer_wake_source_en); endproperty
	property p_idle; !timer_assigned [*3] |-> !timer_wake_event && !cyclic_sense_sample; endproperty
	property p_pulse; cyclic_sense_sample |=> !cyclic_sense_sample; endproperty
	a_gate: assert property (p_gate) else $error("gpio pull active off wake");
	a_soft: assert property (p_soft) else $error("soft reset left bits");
	a_keep: assert property (p_keep) else $error("restart lost kept bits");
	a_rst_hs: assert property (p_rst_hs) else $error("restart left timer on");
	a_clr: assert property (p_clr) else $error("switch clear left timer on");
	a_wake: assert property (p_wake) else $error("wake event while disabled");
	a_idle: assert property (p_idle) else $error("timer ran unassigned");
	a_pulse: assert property (p_pulse) else $error("sense pulse too long");
	c_wake: cover property (timer_wake_event);
	c_sense: cover property (cyclic_sense_sample);
	c_hs: cover property ($rose(high_side_switch_out));
endmodule
bind wpt_regs wpt_regs_sva #(.TICK_CYC(TICK_CYC)) i_wpt_regs_sva (
	.sys_clk(sys_clk), .rst_b(rst_b), .soft_reset_req(soft_reset_req), .restart_req(restart_req),
	.gpio_is_wake_in(gpio_is_wake_in), .timer_assigned(timer_assigned), .cyclic_sense_sel(cyclic_sense_sel),
	.hs_clear_in_restart(hs_clear_in_restart), .timer_wake_source_en(timer_wake_source_en),
	.gpio_wake_pull_sel(gpio_wake_pull_sel), .wake_pin_pull_sel(wake_pin_pull_sel),
	.can_fast_mode(can_fast_mode), .high_side_switch_out(high_side_switch_out),
	.cyclic_sense_sample(cyclic_sense_sample), .timer_wake_event(timer_wake_event)
);

// file: testbench/wpt_spi_host.sv
// spi host model sending 16-bit frames to the register block
// assumes mode 0, 160 ns sclk, pins changed at falling sys_clk
`timescale 1ns/1ns
module wpt_spi_host (
	input  wire logic              sys_clk,
	input  wire logic              spi_miso,
	output wpt_pkg::wpt_spi_pins_t spi_pins
);
	import wpt_pkg::*;
	// ----------------------------------------
	// frame driver
	// ----------------------------------------
	initial spi_pins = 3'h4;
	task automatic xfer(input logic [15:0] w, output logic [7:0] rd);
		rd = 8'h00;
		@(negedge sys_clk);
		spi_pins.spi_chip_select_n = 1'h0;
		for (int i = 15; i >= 0; i--) begin
			spi_pins.spi_mosi = w[i];
			repeat (4) @(negedge sys_clk);
			spi_pins.spi_sclk = 1'h1;
			if (i < 8) rd[i] = spi_miso;
			repeat (4) @(negedge sys_clk);
			spi_pins.spi_sclk = 1'h0;
		end
		spi_pins.spi_mosi = ~spi_pins.spi_mosi;
		repeat (4) @(negedge sys_clk);
		spi_pins.spi_chip_select_n = 1'h1;
		repeat (3) @(negedge sys_clk);
	endtask
endmodule

// file: testbench/testbench.sv
// self-checking bench for the wake pull, bus and timer registers
// assumes wpt_regs, the wpt_spi_host model and the bound checker
`timescale 1ns/1ns
module testbench;
	import wpt_pkg::*;
	// ----------------------------------------
	// stimulus and checks
	// ----------------------------------------
	localparam int TK = 5;
	logic sys_clk = 1'h0;
	logic rst_b = 1'h0;
	logic srst, rrq, gwk, tas, csel, hclr, wen, miso, moe, fast, hs, sns, wke;
	wpt_spi_pins_t pins;
	wpt_pull_drive_t gp, wp;
	logic [15:0] nw, ns, h, n;
	int mismatches = 0;
	int n_checks = 0;
	always #10 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		nw <= nw + 16'(wke);
		ns <= ns + 16'(sns);
	end
	wpt_spi_host i_wpt_spi_host (.sys_clk(sys_clk), .spi_miso(miso), .spi_pins(pins));
	wpt_regs #(.TICK_CYC(TK)) i_wpt_regs (
		.sys_clk(sys_clk), .rst_b(rst_b), .spi_pins(pins), .spi_miso(miso), .spi_miso_oe_n(moe),
		.soft_reset_req(srst), .restart_req(rrq), .gpio_is_wake_in(gwk), .timer_assigned(tas),
		.cyclic_sense_sel(csel), .hs_clear_in_restart(hclr), .timer_wake_source_en(wen),
		.gpio_wake_pull_sel(gp), .wake_pin_pull_sel(wp), .can_fast_mode(fast),
		.high_side_switch_out(hs), .cyclic_sense_sample(sns), .timer_wake_event(wke)
	);
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		n_checks++;
		if (s !== e) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] x;
		i_wpt_spi_host.xfer({1'h1, a, d}, x);
	endtask
	task automatic rdc(input logic [6:0] a, input logic [7:0] e);
		logic [7:0] x;
		i_wpt_spi_host.xfer({1'h0, a, 8'h00}, x);
		chk(16'(x), 16'(e));
	endtask
	task automatic meas(input logic l, output logic [15:0] c);
		c = 16'h0000;
		while (hs === l) begin
			@(negedge sys_clk);
			c++;
			if (c == 16'h4E20) begin
				mismatches++;
				$display("[FAIL] %0t timer wait expired", $time);
				complete_run();
			end
		end
	endtask
	task automatic t_reset();
		logic [6:0] a[4] = '{7'h08, 7'h0B, 7'h0C, 7'h01};
		foreach (a[i]) rdc(a[i], 8'h00);
		chk(16'(moe), 16'h0001);
		$display("t_reset done");
	endtask
	task automatic t_pull();
		logic [1:0] c;
		logic [2:0] e;
		gwk = 1'h1;
		for (int i = 0; i < 4; i++) begin
			c = 2'(i);
			e = {c == 2'h2, c == 2'h1, c == 2'h3};
			wr(7'h08, {c, 4'hF, c});
			rdc(7'h08, {c, 4'h0, c});
			chk(16'(wp), 16'(e));
			chk(16'(gp), 16'(e));
		end
		gwk = 1'h0;
		repeat (3) @(negedge sys_clk);
		chk(16'(gp), 16'h0000);
		wr(7'h0B, 8'hFF);
		rdc(7'h0B, 8'h10);
		chk(16'(fast), 16'h0001);
		wr(7'h0B, 8'hEF);
		rdc(7'h0B, 8'h00);
		chk(16'(fast), 16'h0000);
		$display("t_pull done");
	endtask
	task automatic t_timer();
		logic [15:0] w[5] = '{16'h0001, 16'h0003, 16'h000A, 16'h0064, 16'h00C8};
		logic [7:0] cf[4] = '{8'h60, 8'h00, 8'h60, 8'h70};
		wr(7'h0C, 8'h10);
		repeat (20) @(negedge sys_clk);
		chk(16'(hs), 16'h0000);
		tas = 1'h1;
		foreach (cf[i]) begin
			wr(7'h0C, cf[i]);
			repeat (10) @(negedge sys_clk);
			chk(16'(hs), 16'(cf[i] == 8'h60));
		end
		for (int c = 1; c < 6; c++) begin
			wr(7'h0C, {1'h1, 3'(c), 4'h4});
			meas(1'h0, n);
			meas(1'h1, h);
			chk(h, w[c - 1] * 16'(TK));
			rdc(7'h0C, {1'h0, 3'(c), 4'h4});
		end
		{csel, wen} = 2'h3;
		wr(7'h0C, 8'h10);
		meas(1'h0, n);
		meas(1'h1, h);
		meas(1'h0, n);
		chk(h + n, 16'(100 * TK));
		meas(1'h1, h);
		repeat (10) @(negedge sys_clk);
		{nw, ns} = 32'h0;
		repeat (100 * TK) @(negedge sys_clk);
		chk(nw, 16'h0001);
		chk(ns, 16'h0001);
		$display("t_timer done");
	endtask
	task automatic t_reinit();
		wr(7'h0C, 8'h60);
		csel = 1'h0;
		hclr = 1'h1;
		@(negedge sys_clk);
		hclr = 1'h0;
		rdc(7'h0C, 8'h60);
		csel = 1'h1;
		hclr = 1'h1;
		@(negedge sys_clk);
		hclr = 1'h0;
		rdc(7'h0C, 8'h00);
		chk(16'(hs), 16'h0000);
		wr(7'h08, 8'h81);
		wr(7'h0B, 8'h10);
		wr(7'h0C, 8'h60);
		repeat (4) @(negedge sys_clk);
		rrq = 1'h1;
		@(negedge sys_clk);
		rrq = 1'h0;
		rdc(7'h08, 8'h81);
		rdc(7'h0B, 8'h10);
		rdc(7'h0C, 8'h00);
		srst = 1'h1;
		@(negedge sys_clk);
		srst = 1'h0;
		rdc(7'h08, 8'h00);
		rdc(7'h0B, 8'h00);
		$display("t_reinit done");
	endtask
	initial begin
		{srst, rrq, gwk, tas, csel, hclr, wen} = 7'h00;
		{nw, ns} = 32'h0;
		repeat (6) @(negedge sys_clk);
		rst_b = 1'h1;
		t_reset();
		t_pull();
		t_timer();
		t_reinit();
		complete_run();
	end
endmodule
